// file: inc/lpmc_cfg.svh
// constants for the low-power mode controller: vector addresses and timing
`ifndef LPMC_CFG_SVH
`define LPMC_CFG_SVH

// ---------------------------------------------------------------
// vector table
// ---------------------------------------------------------------
`define LPMC_VEC_BASE 16'hFFD4
`define LPMC_VEC_RESET 16'hFFFE
`define LPMC_VEC_SWI 16'hFFFC
`define LPMC_VEC_IRQ 16'hFFFA
`define LPMC_VEC_TIM1_CH0 16'hFFF6
`define LPMC_VEC_TIM1_CH1 16'hFFF4
`define LPMC_VEC_TIM1_OVF 16'hFFF2
`define LPMC_VEC_SPI_RX 16'hFFEA
`define LPMC_VEC_SPI_TX 16'hFFE8
`define LPMC_VEC_KBD 16'hFFE0
`define LPMC_VEC_CONV 16'hFFDE
`define LPMC_VEC_TBM 16'hFFDC
`define LPMC_SRC_COUNT 21

// ---------------------------------------------------------------
// reset values and timing
// ---------------------------------------------------------------
`define LPMC_MASK_RESET 1'b1
`define LPMC_SRC_SEL_RESET 1'b0
`define LPMC_CLK_NS 8
`define LPMC_OSC_STAB_NS 32768
`define LPMC_OSC_STAB_CYCLES ((`LPMC_OSC_STAB_NS + `LPMC_CLK_NS - 1) / `LPMC_CLK_NS)

`endif

// file: inc/lpmc_pkg.sv
// types shared by the low-power mode controller
package lpmc_pkg;

	// controller states
	typedef enum logic [2:0]
	{
		LPMC_ST_RESET = 3'h0,
		LPMC_ST_RUN = 3'h1,
		LPMC_ST_WAIT = 3'h2,
		LPMC_ST_STOP = 3'h3,
		LPMC_ST_STAB = 3'h4
	} lpmc_state_type;

	// mode reported to the rest of the chip
	typedef enum logic [1:0]
	{
		LPMC_MODE_RUN = 2'h0,
		LPMC_MODE_WAIT = 2'h1,
		LPMC_MODE_STOP = 2'h2
	} lpmc_mode_type;

endpackage : lpmc_pkg

// file: inc/lpmc_vec_if.sv
// request vector and selected vector between controller and selector
interface lpmc_vec_if #(parameter int N = 21);
	logic [N-1:0] req;
	logic hit;
	logic [15:0] addr;
	logic [4:0] index;

	modport requester (output req, input hit, input addr, input index);
	modport selector (input req, output hit, output addr, output index);
endinterface : lpmc_vec_if

// file: logic/lpmc_vector_select.sv
// priority selector: highest pending source wins, vector address from its slot
`include "lpmc_cfg.svh"

module lpmc_vector_select #(
	parameter int N = `LPMC_SRC_COUNT
)(
	lpmc_vec_if.selector vec
);
	import lpmc_pkg::*;

	// ---------------------------------------------------------------
	// scan upward so that a higher address overrides a lower one
	// ---------------------------------------------------------------
	always_comb
	begin
		vec.hit = 1'b0;
		vec.index = 5'h00;
		vec.addr = `LPMC_VEC_BASE;
		for (int i = 0; i < N; i++)
		begin
			if (vec.req[i])
			begin
				vec.hit = 1'b1;
				vec.index = 5'(i);
				vec.addr = `LPMC_VEC_BASE + 16'(2 * i); // two bytes per slot
			end
		end
	end

endmodule : lpmc_vector_select

// file: logic/lpmc_top.sv
// low-power mode controller: wait/stop entry, clock gating, wake-up and vectors
//
// How it works
// - wait stops processor clock, bus runs
// - stop halts processor; bus too unless oscillator-run
// - converter runs in wait, its request wakes
// - stop idles converter, aborts pending conversion
// - no keepalive: oscillator, loop, generator outputs low
// - stop clears source select, stays cleared
// - keepalive set: loop off, oscillator keeps running
// - watchdog active in wait, resets on timeout
// - stop gates watchdog clock, clears prescaler
// - stop only when enabled, else ignored
// - wait/stop clear mask; reset wake sets it
// - processor clock held off during oscillator settle
// - external interrupt wakes only when unmasked
// - break active in wait, sets wait-break flag
// - break inactive in stop, state kept
// - two-byte vectors, priority rises with address
// - serial peripheral transmit/receive vector addresses
// - timer one overflow/channel vector addresses
// - wake restarts clocks and fetches vector
`include "lpmc_cfg.svh"

module lpmc_top #(
	parameter int SRC_COUNT = `LPMC_SRC_COUNT,
	parameter int OSC_STAB_CYCLES = `LPMC_OSC_STAB_CYCLES
)(
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic wait_exec_in,
	input wire logic stop_exec_in,
	input wire logic osc_run_in_stop_in,
	input wire logic oscillator_stop_keepalive_in,
	input wire logic stop_enable_in,
	input wire logic pll_power_on_in,
	input wire logic pll_source_select_write_in,
	input wire logic pll_source_select_data_in,
	input wire logic interrupt_mask_write_in,
	input wire logic interrupt_mask_data_in,
	input wire logic [SRC_COUNT-1:0] irq_req_in,
	input wire logic irq_pin_n_in,
	input wire logic irq_wake_mask_in,
	input wire logic watchdog_enable_in,
	input wire logic watchdog_timeout_in,
	input wire logic break_enable_in,
	input wire logic break_hit_in,
	input wire logic wait_break_flag_clear_in,
	output lpmc_pkg::lpmc_mode_type mode_out,
	output logic cpu_clock_enable_out,
	output logic bus_clock_enable_out,
	output logic interrupt_mask_out,
	output logic converter_active_out,
	output logic converter_abort_out,
	output logic oscillator_enable_out,
	output logic pll_enable_out,
	output logic crystal_clock_enable_out,
	output logic generator_output_enable_out,
	output logic generator_interrupt_enable_out,
	output logic pll_source_select_out,
	output logic watchdog_clock_enable_out,
	output logic watchdog_prescaler_clear_out,
	output logic watchdog_reset_out,
	output logic break_active_out,
	output logic wait_break_flag_out,
	output logic irq_pending_out,
	output logic vector_fetch_out,
	output logic [15:0] vector_address_out
);
	import lpmc_pkg::*;

	// ---------------------------------------------------------------
	// constants
	// ---------------------------------------------------------------
	localparam int CW = $clog2(OSC_STAB_CYCLES + 1);
	localparam logic [CW-1:0] STAB_LOAD = CW'(OSC_STAB_CYCLES);
	localparam int IDX_IRQ = (`LPMC_VEC_IRQ - `LPMC_VEC_BASE) / 2;
	localparam int IDX_SWI = (`LPMC_VEC_SWI - `LPMC_VEC_BASE) / 2;
	localparam int IDX_KBD = (`LPMC_VEC_KBD - `LPMC_VEC_BASE) / 2;
	localparam int IDX_TBM = (`LPMC_VEC_TBM - `LPMC_VEC_BASE) / 2;
	localparam int IDX_CONV = (`LPMC_VEC_CONV - `LPMC_VEC_BASE) / 2;
	localparam int IDX_SPI_TX = (`LPMC_VEC_SPI_TX - `LPMC_VEC_BASE) / 2;
	localparam int IDX_SPI_RX = (`LPMC_VEC_SPI_RX - `LPMC_VEC_BASE) / 2;
	localparam int IDX_T1_OVF = (`LPMC_VEC_TIM1_OVF - `LPMC_VEC_BASE) / 2;
	localparam int IDX_T1_CH1 = (`LPMC_VEC_TIM1_CH1 - `LPMC_VEC_BASE) / 2;
	localparam int IDX_T1_CH0 = (`LPMC_VEC_TIM1_CH0 - `LPMC_VEC_BASE) / 2;

	// ---------------------------------------------------------------
	// reset release and pin synchroniser
	// ---------------------------------------------------------------
	logic [1:0] rst_sync_reg;
	logic [1:0] rst_sync_next;
	logic rst_n;
	logic [1:0] pin_sync_reg;
	logic [1:0] pin_sync_next;
	logic pin_last_reg;
	logic pin_last_next;
	logic pin_fall;

	// reset is asserted at once but released two edges later
	always_comb
	begin
		rst_sync_next = {rst_sync_reg[0], 1'b1};
	end

	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			rst_sync_reg <= 2'h0;
		else
			rst_sync_reg <= rst_sync_next;
	end

	assign rst_n = rst_sync_reg[1];

	// pin is async; edge detection only looks at the second stage
	always_comb
	begin
		pin_sync_next = {pin_sync_reg[0], irq_pin_n_in};
		pin_last_next = pin_sync_reg[1];
	end

	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_sync_reg <= 2'h3;
			pin_last_reg <= 1'b1;
		end
		else
		begin
			pin_sync_reg <= pin_sync_next;
			pin_last_reg <= pin_last_next;
		end
	end

	assign pin_fall = pin_last_reg & ~pin_sync_reg[1];

	// ---------------------------------------------------------------
	// wake request gathering and vector selection
	// ---------------------------------------------------------------
	lpmc_vec_if #(.N(SRC_COUNT)) vec ();

	lpmc_vector_select #(.N(SRC_COUNT)) u_vec (
		.vec(vec.selector)
	);

	lpmc_state_type state_reg;
	lpmc_state_type state_next;
	logic irq_pending_reg;
	logic irq_pending_next;
	logic break_pending_reg;
	logic break_pending_next;
	logic [SRC_COUNT-1:0] req_all;
	logic [SRC_COUNT-1:0] stop_wake_set;

	// in stop only the pin, keyboard and (oscillator alive) timebase can wake
	always_comb
	begin
		req_all = irq_req_in;
		req_all[IDX_IRQ] = irq_pending_reg & ~irq_wake_mask_in;
		req_all[IDX_SWI] = break_pending_reg;
		stop_wake_set = '0;
		stop_wake_set[IDX_IRQ] = 1'b1;
		stop_wake_set[IDX_KBD] = 1'b1;
		stop_wake_set[IDX_TBM] = osc_run_in_stop_in;
		if (state_reg == LPMC_ST_STOP)
			vec.req = req_all & stop_wake_set;
		else
			vec.req = req_all; // converter bit wakes from wait like any other
	end

	// ---------------------------------------------------------------
	// mode sequencer and outputs
	// ---------------------------------------------------------------
	lpmc_mode_type mode_reg;
	lpmc_mode_type mode_next;
	logic cpu_en_reg;
	logic cpu_en_next;
	logic bus_en_reg;
	logic bus_en_next;
	logic mask_reg;
	logic mask_next;
	logic conv_active_reg;
	logic conv_active_next;
	logic conv_abort_reg;
	logic conv_abort_next;
	logic osc_en_reg;
	logic osc_en_next;
	logic pll_en_reg;
	logic pll_en_next;
	logic xtal_en_reg;
	logic xtal_en_next;
	logic gen_out_en_reg;
	logic gen_out_en_next;
	logic gen_int_en_reg;
	logic gen_int_en_next;
	logic src_sel_reg;
	logic src_sel_next;
	logic wd_clk_en_reg;
	logic wd_clk_en_next;
	logic wd_pre_clr_reg;
	logic wd_pre_clr_next;
	logic wd_reset_reg;
	logic wd_reset_next;
	logic brk_active_reg;
	logic brk_active_next;
	logic wbrk_flag_reg;
	logic wbrk_flag_next;
	logic fetch_reg;
	logic fetch_next;
	logic [15:0] vaddr_reg;
	logic [15:0] vaddr_next;
	logic [4:0] held_idx_reg;
	logic [4:0] held_idx_next;
	logic [CW-1:0] stab_cnt_reg;
	logic [CW-1:0] stab_cnt_next;
	logic fetch_idx_irq;
	logic fetch_idx_swi;

	// one pulse per taken vector; the chosen slot drops its pending latch
	always_comb
	begin
		fetch_idx_irq = 1'b0;
		fetch_idx_swi = 1'b0;
		if (fetch_reg && vaddr_reg == `LPMC_VEC_IRQ)
			fetch_idx_irq = 1'b1;
		if (fetch_reg && vaddr_reg == `LPMC_VEC_SWI)
			fetch_idx_swi = 1'b1;
	end

	// next-state logic for all control state
	always_comb
	begin
		state_next = state_reg;
		mask_next = mask_reg;
		src_sel_next = src_sel_reg;
		stab_cnt_next = stab_cnt_reg;
		held_idx_next = held_idx_reg;
		conv_abort_next = 1'b0;
		wd_pre_clr_next = 1'b0;
		wd_reset_next = 1'b0;
		fetch_next = 1'b0;
		vaddr_next = vaddr_reg;
		// a new edge wins over the clear from its own vector fetch
		irq_pending_next = pin_fall | (irq_pending_reg & ~fetch_idx_irq);
		break_pending_next = (break_hit_in & break_enable_in) | (break_pending_reg & ~fetch_idx_swi);
		// set wins over software clear
		wbrk_flag_next = wbrk_flag_reg & ~wait_break_flag_clear_in;
		if (state_reg == LPMC_ST_WAIT && break_hit_in && break_enable_in)
			wbrk_flag_next = 1'b1;
		if (pll_source_select_write_in)
			src_sel_next = pll_source_select_data_in;
		if (interrupt_mask_write_in)
			mask_next = interrupt_mask_data_in;

		case (state_reg)
			LPMC_ST_RESET:
			begin
				mask_next = 1'b1; // reset wake leaves mask set
				fetch_next = 1'b1;
				vaddr_next = `LPMC_VEC_RESET;
				state_next = LPMC_ST_RUN;
			end
			LPMC_ST_RUN:
			begin
				if (watchdog_enable_in && watchdog_timeout_in)
				begin
					wd_reset_next = 1'b1;
					state_next = LPMC_ST_RESET;
				end
				else if (stop_exec_in && stop_enable_in) // disabled stop is a no-op
				begin
					mask_next = 1'b0;
					conv_abort_next = 1'b1;
					wd_pre_clr_next = 1'b1;
					src_sel_next = 1'b0; // fall back to halved crystal
					state_next = LPMC_ST_STOP;
				end
				else if (wait_exec_in)
				begin
					mask_next = 1'b0;
					state_next = LPMC_ST_WAIT;
				end
			end
			LPMC_ST_WAIT:
			begin
				if (watchdog_enable_in && watchdog_timeout_in)
				begin
					wd_reset_next = 1'b1; // watchdog keeps running in wait
					state_next = LPMC_ST_RESET;
				end
				else if (vec.hit)
				begin
					fetch_next = 1'b1;
					vaddr_next = vec.addr;
					state_next = LPMC_ST_RUN;
				end
			end
			LPMC_ST_STOP:
			begin
				if (vec.hit)
				begin
					held_idx_next = vec.index;
					stab_cnt_next = STAB_LOAD;
					state_next = LPMC_ST_STAB;
				end
			end
			LPMC_ST_STAB:
			begin
				// processor waits here until the oscillator has settled
				if (stab_cnt_reg <= CW'(1))
				begin
					fetch_next = 1'b1;
					vaddr_next = `LPMC_VEC_BASE + {10'h000, held_idx_reg, 1'b0};
					state_next = LPMC_ST_RUN;
				end
				else
					stab_cnt_next = stab_cnt_reg - CW'(1);
			end
			default:
				state_next = LPMC_ST_RESET;
		endcase

		// clock and module enables follow the state being entered
		mode_next = LPMC_MODE_RUN;
		cpu_en_next = 1'b1;
		bus_en_next = 1'b1;
		conv_active_next = 1'b1;
		osc_en_next = 1'b1;
		pll_en_next = pll_power_on_in;
		xtal_en_next = 1'b1;
		gen_out_en_next = 1'b1;
		gen_int_en_next = 1'b1;
		wd_clk_en_next = 1'b1;
		brk_active_next = break_enable_in;
		case (state_next)
			LPMC_ST_WAIT:
			begin
				mode_next = LPMC_MODE_WAIT;
				cpu_en_next = 1'b0; // bus clock keeps running
			end
			LPMC_ST_STOP:
			begin
				mode_next = LPMC_MODE_STOP;
				cpu_en_next = 1'b0;
				bus_en_next = osc_run_in_stop_in;
				conv_active_next = 1'b0;
				osc_en_next = oscillator_stop_keepalive_in;
				pll_en_next = 1'b0; // loop off either way
				xtal_en_next = oscillator_stop_keepalive_in;
				gen_out_en_next = oscillator_stop_keepalive_in;
				gen_int_en_next = oscillator_stop_keepalive_in;
				wd_clk_en_next = 1'b0;
				brk_active_next = 1'b0; // registers untouched, only idled
			end
			LPMC_ST_STAB:
			begin
				mode_next = LPMC_MODE_STOP;
				cpu_en_next = 1'b0;
				conv_active_next = 1'b0; // resumes only once running again
				pll_en_next = 1'b0;
				wd_clk_en_next = 1'b0;
				brk_active_next = 1'b0;
			end
			default:
			begin
				mode_next = LPMC_MODE_RUN;
			end
		endcase
	end

	// registers only; state after reset is the reset-vector fetch
	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg <= LPMC_ST_RESET;
			mode_reg <= LPMC_MODE_RUN;
			cpu_en_reg <= 1'b0;
			bus_en_reg <= 1'b1;
			mask_reg <= `LPMC_MASK_RESET;
			conv_active_reg <= 1'b0;
			conv_abort_reg <= 1'b0;
			osc_en_reg <= 1'b1;
			pll_en_reg <= 1'b0;
			xtal_en_reg <= 1'b1;
			gen_out_en_reg <= 1'b1;
			gen_int_en_reg <= 1'b1;
			src_sel_reg <= `LPMC_SRC_SEL_RESET;
			wd_clk_en_reg <= 1'b1;
			wd_pre_clr_reg <= 1'b0;
			wd_reset_reg <= 1'b0;
			brk_active_reg <= 1'b0;
			wbrk_flag_reg <= 1'b0;
			irq_pending_reg <= 1'b0;
			break_pending_reg <= 1'b0;
			fetch_reg <= 1'b0;
			vaddr_reg <= `LPMC_VEC_RESET;
			held_idx_reg <= 5'h00;
			stab_cnt_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
			mode_reg <= mode_next;
			cpu_en_reg <= cpu_en_next;
			bus_en_reg <= bus_en_next;
			mask_reg <= mask_next;
			conv_active_reg <= conv_active_next;
			conv_abort_reg <= conv_abort_next;
			osc_en_reg <= osc_en_next;
			pll_en_reg <= pll_en_next;
			xtal_en_reg <= xtal_en_next;
			gen_out_en_reg <= gen_out_en_next;
			gen_int_en_reg <= gen_int_en_next;
			src_sel_reg <= src_sel_next;
			wd_clk_en_reg <= wd_clk_en_next;
			wd_pre_clr_reg <= wd_pre_clr_next;
			wd_reset_reg <= wd_reset_next;
			brk_active_reg <= brk_active_next;
			wbrk_flag_reg <= wbrk_flag_next;
			irq_pending_reg <= irq_pending_next;
			break_pending_reg <= break_pending_next;
			fetch_reg <= fetch_next;
			vaddr_reg <= vaddr_next;
			held_idx_reg <= held_idx_next;
			stab_cnt_reg <= stab_cnt_next;
		end
	end

	// ---------------------------------------------------------------
	// outputs, all straight from flip-flops
	// ---------------------------------------------------------------
	assign mode_out = mode_reg;
	assign cpu_clock_enable_out = cpu_en_reg;
	assign bus_clock_enable_out = bus_en_reg;
	assign interrupt_mask_out = mask_reg;
	assign converter_active_out = conv_active_reg;
	assign converter_abort_out = conv_abort_reg;
	assign oscillator_enable_out = osc_en_reg;
	assign pll_enable_out = pll_en_reg;
	assign crystal_clock_enable_out = xtal_en_reg;
	assign generator_output_enable_out = gen_out_en_reg;
	assign generator_interrupt_enable_out = gen_int_en_reg;
	assign pll_source_select_out = src_sel_reg;
	assign watchdog_clock_enable_out = wd_clk_en_reg;
	assign watchdog_prescaler_clear_out = wd_pre_clr_reg;
	assign watchdog_reset_out = wd_reset_reg;
	assign break_active_out = brk_active_reg;
	assign wait_break_flag_out = wbrk_flag_reg;
	assign irq_pending_out = irq_pending_reg;
	assign vector_fetch_out = fetch_reg;
	assign vector_address_out = vaddr_reg;

endmodule : lpmc_top

// file: bench/lpmc_props.sv
// port-level checker for the low-power mode controller
module lpmc_props
	import lpmc_pkg::*;
#(
	parameter int OSC_STAB_CYCLES = 4
)(
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic wait_exec_in,
	input wire logic stop_exec_in,
	input wire logic osc_run_in_stop_in,
	input wire logic oscillator_stop_keepalive_in,
	input wire logic stop_enable_in,
	input wire logic watchdog_enable_in,
	input wire logic watchdog_timeout_in,
	input wire logic wait_break_flag_clear_in,
	input lpmc_pkg::lpmc_mode_type mode_out,
	input wire logic cpu_clock_enable_out,
	input wire logic bus_clock_enable_out,
	input wire logic interrupt_mask_out,
	input wire logic converter_active_out,
	input wire logic converter_abort_out,
	input wire logic oscillator_enable_out,
	input wire logic pll_enable_out,
	input wire logic crystal_clock_enable_out,
	input wire logic generator_output_enable_out,
	input wire logic generator_interrupt_enable_out,
	input wire logic pll_source_select_out,
	input wire logic watchdog_clock_enable_out,
	input wire logic watchdog_prescaler_clear_out,
	input wire logic watchdog_reset_out,
	input wire logic break_active_out,
	input wire logic wait_break_flag_out,
	input wire logic vector_fetch_out,
	input wire logic [15:0] vector_address_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);

	// ------------------------------------------------------------
	// settle counter: an early exit from stop would skip the oscillator warm-up
	// ------------------------------------------------------------
	logic [15:0] osc_up_reg;
	logic [15:0] osc_up_next;

	// count stop cycles with the oscillator running
	always_comb
	begin
		osc_up_next = 16'h0000;
		if (mode_out == LPMC_MODE_STOP && oscillator_enable_out)
		begin
			osc_up_next = osc_up_reg + 16'h0001;
		end
	end

	// register the count
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			osc_up_reg <= 16'h0000;
		end
		else
		begin
			osc_up_reg <= osc_up_next;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	sequence s_stop_entry;
		mode_out == LPMC_MODE_STOP && $past(mode_out) != LPMC_MODE_STOP;
	endsequence

	a_wait_bus_runs: assert property (mode_out == LPMC_MODE_WAIT |-> !cpu_clock_enable_out && bus_clock_enable_out)
		else $error("wait mode clock enables wrong");
	a_stop_bus_gate: assert property (s_stop_entry |-> !cpu_clock_enable_out && bus_clock_enable_out == osc_run_in_stop_in)
		else $error("stop entry clock enables wrong");
	a_stop_side_pulses: assert property (s_stop_entry |-> converter_abort_out && watchdog_prescaler_clear_out && !watchdog_clock_enable_out && !pll_source_select_out)
		else $error("stop entry pulses or gating missing");
	a_stop_gen_low: assert property (s_stop_entry ##0 !oscillator_stop_keepalive_in |-> !(oscillator_enable_out | crystal_clock_enable_out | generator_output_enable_out | generator_interrupt_enable_out))
		else $error("generator outputs not low in stop");
	a_stop_pll_off: assert property (s_stop_entry |-> !pll_enable_out && oscillator_enable_out == oscillator_stop_keepalive_in)
		else $error("loop or oscillator wrong in stop");
	a_stop_idle_units: assert property (mode_out == LPMC_MODE_STOP |-> !converter_active_out && !break_active_out)
		else $error("converter or break active in stop");
	a_stop_refused: assert property (stop_exec_in && !stop_enable_in && mode_out == LPMC_MODE_RUN |=> mode_out != LPMC_MODE_STOP)
		else $error("disabled stop was taken");
	a_wait_clears_mask: assert property (wait_exec_in && cpu_clock_enable_out && mode_out == LPMC_MODE_RUN && !watchdog_timeout_in |=> !interrupt_mask_out && mode_out == LPMC_MODE_WAIT)
		else $error("wait did not clear mask");
	a_settle_hold: assert property ($rose(cpu_clock_enable_out) && $past(mode_out) == LPMC_MODE_STOP |-> osc_up_reg >= 16'(OSC_STAB_CYCLES - 1))
		else $error("processor clock before settle");
	a_fetch_even: assert property (vector_fetch_out |-> cpu_clock_enable_out && !vector_address_out[0] && vector_address_out >= 16'hFFD4)
		else $error("bad vector fetch");
	a_flag_sticky: assert property (wait_break_flag_out && !wait_break_flag_clear_in |=> wait_break_flag_out)
		else $error("wait-break flag dropped");
	a_wdog_reset: assert property (mode_out == LPMC_MODE_WAIT && watchdog_enable_in && watchdog_timeout_in |-> ##[1:2] watchdog_reset_out)
		else $error("watchdog timeout ignored in wait");

	c_wait_entry: cover property (mode_out == LPMC_MODE_WAIT && $past(mode_out) == LPMC_MODE_RUN);
	c_stop_entry: cover property (s_stop_entry);
	c_wdog_reset: cover property (watchdog_reset_out);
	c_break_flag: cover property ($rose(wait_break_flag_out));
endmodule : lpmc_props

bind lpmc_top lpmc_props #(.OSC_STAB_CYCLES(OSC_STAB_CYCLES)) u_props (.*);

// file: bench/lpmc_core_model.sv
// processor-side partner: issues wait/stop only while clocked, logs vector fetches
module lpmc_core_model
(
	input wire logic clk_in,
	input wire logic cpu_clock_enable_in,
	input wire logic do_wait_in,
	input wire logic do_stop_in,
	input wire logic vector_fetch_in,
	input wire logic [15:0] vector_address_in,
	output logic wait_exec_out = 1'b0,
	output logic stop_exec_out = 1'b0,
	output logic [15:0] last_vector_out = 16'h0000,
	output int fetch_count_out = 0
);
	timeunit 1ns;
	timeprecision 1ps;
	// an instruction can only execute while the processor clock runs
	always_ff @(posedge clk_in)
	begin
		wait_exec_out <= do_wait_in && cpu_clock_enable_in;
		stop_exec_out <= do_stop_in && cpu_clock_enable_in;
		if (vector_fetch_in)
		begin
			last_vector_out <= vector_address_in;
			fetch_count_out <= fetch_count_out + 1;
		end
	end
endmodule : lpmc_core_model

// file: bench/low_power_mode_control_tb.sv
// self-checking bench for the low-power mode controller
module low_power_mode_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import lpmc_pkg::*;

	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic clk = 1'b0, reset_n = 1'b0, do_wait = 1'b0, do_stop = 1'b0, wait_exec, stop_exec;
	logic osc_run = 1'b0, keepalive = 1'b0, stop_en = 1'b1, pll_on = 1'b1, src_wr = 1'b0;
	logic src_dat = 1'b0, mask_wr = 1'b0, mask_dat = 1'b1, irq_pin_n = 1'b1, wake_mask = 1'b0;
	logic wdog_en = 1'b0, wdog_to = 1'b0, brk_en = 1'b1, brk_hit = 1'b0, flag_clr = 1'b0;
	logic [20:0] irq_req = '0;
	lpmc_mode_type mode;
	logic cpu_en, bus_en, imask, conv_act, osc_en, pll_en, xtal_en, gen_en, genint_en, src_sel;
	logic wdog_clk, brk_act, brk_flag, fetch, pend;
	logic [15:0] vaddr, last_vec;
	int fetch_count, errors = 0, compares = 0, idx, seed;
	int corner[6] = '{10, 11, 15, 16, 17, 5};

	// 125 MHz clock
	always #4 clk = ~clk;

	lpmc_top #(.OSC_STAB_CYCLES(4)) dut (.clk_in(clk), .reset_n_in(reset_n),
		.wait_exec_in(wait_exec), .stop_exec_in(stop_exec), .osc_run_in_stop_in(osc_run),
		.oscillator_stop_keepalive_in(keepalive), .stop_enable_in(stop_en),
		.pll_power_on_in(pll_on), .pll_source_select_write_in(src_wr),
		.pll_source_select_data_in(src_dat), .interrupt_mask_write_in(mask_wr),
		.interrupt_mask_data_in(mask_dat), .irq_req_in(irq_req), .irq_pin_n_in(irq_pin_n),
		.irq_wake_mask_in(wake_mask), .watchdog_enable_in(wdog_en),
		.watchdog_timeout_in(wdog_to), .break_enable_in(brk_en), .break_hit_in(brk_hit),
		.wait_break_flag_clear_in(flag_clr), .mode_out(mode), .cpu_clock_enable_out(cpu_en),
		.bus_clock_enable_out(bus_en), .interrupt_mask_out(imask),
		.converter_active_out(conv_act), .converter_abort_out(), .oscillator_enable_out(osc_en),
		.pll_enable_out(pll_en), .crystal_clock_enable_out(xtal_en),
		.generator_output_enable_out(gen_en), .generator_interrupt_enable_out(genint_en),
		.pll_source_select_out(src_sel), .watchdog_clock_enable_out(wdog_clk),
		.watchdog_prescaler_clear_out(), .watchdog_reset_out(), .break_active_out(brk_act),
		.wait_break_flag_out(brk_flag), .irq_pending_out(pend), .vector_fetch_out(fetch),
		.vector_address_out(vaddr));

	lpmc_core_model core_model (.clk_in(clk), .cpu_clock_enable_in(cpu_en),
		.do_wait_in(do_wait), .do_stop_in(do_stop), .vector_fetch_in(fetch),
		.vector_address_in(vaddr), .wait_exec_out(wait_exec), .stop_exec_out(stop_exec),
		.last_vector_out(last_vec), .fetch_count_out(fetch_count));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [15:0] vec_of(input int i);
		return 16'hFFD4 + 16'(2 * i);
	endfunction : vec_of

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// one-cycle instruction request; returns once its effect has settled
	task automatic core(input logic w, input logic s);
		@(posedge clk);
		do_wait <= w;
		do_stop <= s;
		@(posedge clk);
		do_wait <= 1'b0;
		do_stop <= 1'b0;
		repeat (3) @(negedge clk);
	endtask : core

	// bounded wait for the next vector fetch, then compare its address
	task automatic wait_fetch(input logic [15:0] exp);
		int n;
		n = fetch_count;
		for (int t = 0; t < 100 && fetch_count == n; t++)
		begin
			@(negedge clk);
		end
		check(last_vec, exp);
	endtask : wait_fetch

	task automatic give_verdict();
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0)
		begin
			$display("*** PASS ***");
		end
		else
		begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : give_verdict

	// hang guard, far beyond the expected run length
	initial
	begin
		repeat (20000) @(posedge clk);
		errors++;
		give_verdict();
	end

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	initial
	begin
		seed = $urandom(28202);
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		wait_fetch(16'hFFFE);
		check(16'(imask), 16'h0001);
		// wait wake-ups: corner vectors first, then random ones, each with lower noise
		for (int k = 0; k < 10; k++)
		begin
			idx = (k < 6) ? corner[k] : int'($urandom_range(18, 0));
			core(1'b1, 1'b0);
			check({14'h0, cpu_en, bus_en}, 16'h0001);
			check({13'h0, mode, imask, conv_act}, 16'h0005);
			@(posedge clk);
			irq_req <= 21'(1 << idx) | (21'($urandom) & 21'((1 << idx) - 1));
			wait_fetch(vec_of(idx));
			@(posedge clk);
			irq_req <= '0;
		end
		// stop refused while disabled, then select the halved loop clock
		@(posedge clk);
		stop_en <= 1'b0;
		core(1'b0, 1'b1);
		check({14'h0, mode}, 16'(LPMC_MODE_RUN));
		@(posedge clk);
		src_wr <= 1'b1;
		src_dat <= 1'b1;
		stop_en <= 1'b1;
		@(posedge clk);
		src_wr <= 1'b0;
		core(1'b0, 1'b1); // no watchdog timeout is raised across stop
		check({14'h0, mode}, 16'(LPMC_MODE_STOP));
		check({14'h0, cpu_en, bus_en}, 16'h0000);
		check({12'h0, osc_en, xtal_en, gen_en, genint_en}, 16'h0000);
		check({12'h0, pll_en, src_sel, wdog_clk, conv_act}, 16'h0000);
		check(16'(brk_act), 16'h0000);
		// a masked pin edge is latched but must not wake the part until unmasked
		@(posedge clk);
		wake_mask <= 1'b1;
		irq_pin_n <= 1'b0;
		repeat (20) @(negedge clk);
		check({13'h0, pend, mode}, 16'h0006);
		@(posedge clk);
		irq_pin_n <= 1'b1;
		wake_mask <= 1'b0;
		wait_fetch(16'hFFFA);
		check({13'h0, imask, src_sel, conv_act}, 16'h0001);
		@(posedge clk);
		keepalive <= 1'b1;
		osc_run <= 1'b1;
		core(1'b0, 1'b1);
		check({13'h0, bus_en, osc_en, pll_en}, 16'h0006);
		@(posedge clk);
		irq_req <= 21'h000010; // timebase wake; no converter result used after stop
		wait_fetch(16'hFFDC);
		@(posedge clk);
		irq_req <= '0;
		// break hit in wait sets the sticky flag
		core(1'b1, 1'b0);
		@(posedge clk);
		brk_hit <= 1'b1;
		@(posedge clk);
		brk_hit <= 1'b0;
		wait_fetch(16'hFFFC);
		check(16'(brk_flag), 16'h0001);
		@(posedge clk);
		flag_clr <= 1'b1;
		mask_wr <= 1'b1;
		@(posedge clk);
		flag_clr <= 1'b0;
		mask_wr <= 1'b0;
		repeat (2) @(negedge clk);
		check({14'h0, brk_flag, imask}, 16'h0001);
		// watchdog timeout in wait forces a reset fetch with the mask set
		@(posedge clk);
		wdog_en <= 1'b1;
		core(1'b1, 1'b0);
		@(posedge clk);
		wdog_to <= 1'b1;
		@(posedge clk);
		wdog_to <= 1'b0;
		wait_fetch(16'hFFFE);
		check(16'(imask), 16'h0001);
		give_verdict();
	end
endmodule : low_power_mode_control_tb
